// ==== hw/buzzer_tone_envelope_oneshot.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "buzzer_map.svh"
module buzzer_tone_envelope_oneshot #(
    parameter int CLK_HZ = 10000000,
    parameter bit INV_OPTION = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [15:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [15:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Buzzer terminals
    output logic tone_out,
    output logic tone_inv_out
);
    import buzzer_pkg::*;
    localparam int SYNC_DIV = `SUB_HZ / `SYNC_HZ;
    // Slow interval is 8192 sub-ticks, one bit more than a 13-bit counter holds
    localparam logic [13:0] STEP_FAST = 14'(64'(`STEP_FAST_US) * `SUB_HZ / `US_PER_S);
    localparam logic [13:0] STEP_SLOW = 14'(64'(`STEP_SLOW_US) * `SUB_HZ / `US_PER_S);
    localparam logic [4:0] BURST_SHORT = 5'(64'(`BURST_SHORT_US) * `SYNC_HZ / `US_PER_S);
    localparam logic [4:0] BURST_LONG = 5'(64'(`BURST_LONG_US) * `SYNC_HZ / `US_PER_S);
    typedef enum logic [2:0] {B_IDLE = 3'b001, B_WAIT = 3'b010, B_RING = 3'b100} burst_state_type;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    wr_type wr_r, wr_nxt;
    logic do_wr;
    reg_sel_type wsel;
    ctrl_type ctrl_r, ctrl_nxt;
    burst_state_type burst_r, burst_nxt;
    logic [2:0] level_r, level_nxt;
    always_comb begin
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        wr_nxt = wr_r;
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        wsel = reg_decode(wr_r.addr);
        do_wr = aw_got_r && w_got_r && !bvalid_r;
        if (awvalid && awready_r) begin
            aw_got_nxt = 1'b1;
            awready_nxt = 1'b0;
            wr_nxt.addr = awaddr;
        end
        if (wvalid && wready_r) begin
            w_got_nxt = 1'b1;
            wready_nxt = 1'b0;
            wr_nxt.data = wdata;
            wr_nxt.strb = wstrb;
        end
        if (do_wr) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
            awready_nxt = 1'b1;
            wready_nxt = 1'b1;
        end
        if (arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = `RESP_OKAY;
            case (reg_decode(araddr))
                SEL_PORT: rdata_nxt = {28'h0, ctrl_r.tone_out_ctrl, ctrl_r.tone_inv_out_ctrl, ctrl_r.port_spare};
                SEL_FREQ: rdata_nxt = {28'h0, ctrl_r.burst_length_sel, ctrl_r.tone_freq_sel};
                // Restart bit always reads zero, trigger bit reads busy
                SEL_ENV: rdata_nxt = {28'h0, burst_r != B_IDLE, 1'b0, ctrl_r.envelope_rate_sel,
                                      ctrl_r.envelope_enable};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wr_r <= '0;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h0;
        end else if (ce) begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            wr_r <= wr_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    // Fractional accumulator: exact average rate, at most one clock of jitter
    logic [31:0] acc_r, acc_nxt;
    logic sub_tick_r, sub_tick_nxt;
    logic [$clog2(SYNC_DIV)-1:0] pre_r, pre_nxt;
    logic sync_tick;
    always_comb begin
        acc_nxt = acc_r + 32'(`SUB_HZ);
        sub_tick_nxt = 1'b0;
        if (acc_nxt >= 32'(CLK_HZ)) begin
            acc_nxt = acc_nxt - 32'(CLK_HZ);
            sub_tick_nxt = 1'b1;
        end
        pre_nxt = sub_tick_r ? pre_r + 1'b1 : pre_r;
        sync_tick = sub_tick_r && (pre_r == ($clog2(SYNC_DIV))'(SYNC_DIV - 1));
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= 32'h0;
            sub_tick_r <= 1'b0;
            pre_r <= '0;
        end else if (ce) begin
            acc_r <= acc_nxt;
            sub_tick_r <= sub_tick_nxt;
            pre_r <= pre_nxt;
        end
    end
    // ----------------------------------------
    // Control registers and burst
    // ----------------------------------------
    logic restart_req, trig_req, trig_acc, tone_active;
    logic [4:0] bcnt_r, bcnt_nxt;
    always_comb begin
        ctrl_nxt = ctrl_r;
        restart_req = 1'b0;
        trig_req = 1'b0;
        if (do_wr && wr_r.strb[0]) begin
            case (wsel)
                SEL_PORT: {ctrl_nxt.tone_out_ctrl, ctrl_nxt.tone_inv_out_ctrl, ctrl_nxt.port_spare} =
                              wr_r.data[3:0];
                SEL_FREQ: {ctrl_nxt.burst_length_sel, ctrl_nxt.tone_freq_sel} = wr_r.data[3:0];
                SEL_ENV: begin
                    ctrl_nxt.envelope_enable = wr_r.data[`F_ENV_EN];
                    ctrl_nxt.envelope_rate_sel = wr_r.data[`F_ENV_RATE];
                    restart_req = wr_r.data[`F_ENV_RST];
                    trig_req = wr_r.data[`F_BURST_TRIG];
                end
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        trig_acc = trig_req && ctrl_r.tone_out_ctrl && (burst_r == B_IDLE);
        burst_nxt = burst_r;
        bcnt_nxt = bcnt_r;
        case (burst_r)
            B_IDLE: if (trig_acc) burst_nxt = B_WAIT;
            B_WAIT: if (sync_tick) begin
                burst_nxt = B_RING;
                bcnt_nxt = 5'h0;
            end
            B_RING: if (sync_tick) begin
                bcnt_nxt = bcnt_r + 5'h1;
                if (bcnt_nxt == (ctrl_r.burst_length_sel ? BURST_LONG : BURST_SHORT))
                    burst_nxt = B_IDLE;
            end
            default: burst_nxt = B_IDLE;
        endcase
        tone_active = !ctrl_r.tone_out_ctrl || (burst_r == B_RING);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Only rate and enable of the envelope register are stored
            ctrl_r <= ctrl_type'({`RST_PORT, `RST_FREQ, 2'(`RST_ENV)});
            burst_r <= B_IDLE;
            bcnt_r <= 5'h0;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            burst_r <= burst_nxt;
            bcnt_r <= bcnt_nxt;
        end
    end
    // ----------------------------------------
    // Envelope
    // ----------------------------------------
    // Step counter restarts with enable, so the first step lands on the nominal interval
    logic [13:0] ecnt_r, ecnt_nxt, interval;
    always_comb begin
        interval = ctrl_r.envelope_rate_sel ? STEP_SLOW : STEP_FAST;
        level_nxt = level_r;
        ecnt_nxt = ecnt_r;
        if (!ctrl_r.envelope_enable) begin
            level_nxt = 3'h0;
            ecnt_nxt = 14'h0;
        end else if (restart_req && tone_active) begin
            level_nxt = 3'h0;
            ecnt_nxt = 14'h0;
        end else if (sub_tick_r) begin
            if (ecnt_r == interval - 14'h1) begin
                ecnt_nxt = 14'h0;
                if (level_r != `LEVEL_MIN)
                    level_nxt = level_r + 3'h1;
            end else
                ecnt_nxt = ecnt_r + 14'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_r <= 3'h0;
            ecnt_r <= 14'h0;
        end else if (ce) begin
            level_r <= level_nxt;
            ecnt_r <= ecnt_nxt;
        end
    end
    // ----------------------------------------
    // Terminals
    // ----------------------------------------
    logic wave;
    logic tone_out_r, tone_inv_out_r;
    tone_wave u_wave (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .sub_tick(sub_tick_r), .run(tone_active),
        .freq_sel(ctrl_r.tone_freq_sel), .level(level_r), .wave_r(wave)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tone_out_r <= 1'b0;
            tone_inv_out_r <= 1'b0;
        end else if (ce) begin
            tone_out_r <= tone_active && wave;
            // Without the inverted option the second terminal is a plain port bit
            tone_inv_out_r <= INV_OPTION ? (tone_active && !wave) : ctrl_r.tone_inv_out_ctrl;
        end
    end
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign tone_out = tone_out_r;
    assign tone_inv_out = tone_inv_out_r;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_freq_zero: assert property (aresetn && !$past(aresetn) |-> ctrl_r.tone_freq_sel == 3'h0)
        else $error("frequency code not cleared by reset");
    a_off_terminal_low: assert property ((ctrl_r.tone_out_ctrl && burst_r == B_IDLE) [*3] |-> !tone_out_r)
        else $error("tone terminal not low while off");
    a_env_off_level: assert property (ce && !ctrl_r.envelope_enable |=> level_r == 3'h0)
        else $error("duty not at maximum with envelope off");
    a_restart_max: assert property (ce && restart_req && ctrl_r.envelope_enable && tone_active |=> level_r == 3'h0)
        else $error("restart did not return maximum duty");
    a_trig_ignored: assert property (ce && trig_req && !ctrl_r.tone_out_ctrl && burst_r == B_IDLE |=> burst_r == B_IDLE)
        else $error("trigger taken while continuous tone on");
    a_trig_busy: assert property (ce && trig_acc |=> burst_r == B_WAIT)
        else $error("accepted trigger did not go busy");
    a_busy_read: assert property (ce && arvalid && arready_r && reg_decode(araddr) == SEL_ENV
                                  |=> rdata_r[`F_BURST_TRIG] == ($past(burst_r) != B_IDLE))
        else $error("trigger bit does not read busy state");
    a_burst_sync_start: assert property (burst_r == B_RING && $past(burst_r) == B_WAIT |-> $past(sync_tick))
        else $error("burst start not on 256 Hz tick");
    a_level_hold_min: assert property (ce && level_r == `LEVEL_MIN && ctrl_r.envelope_enable && !restart_req
                                       |=> level_r == `LEVEL_MIN)
        else $error("minimum duty level not held");
    a_env_step_one: assert property (ce && ctrl_r.envelope_enable && sub_tick_r && ecnt_r == interval - 14'h1
                                     && level_r != `LEVEL_MIN && !restart_req |=> level_r == $past(level_r) + 3'h1)
        else $error("envelope did not step one level");
    a_wr_response: assert property (ce && aw_got_r && w_got_r && !bvalid_r |=> bvalid_r)
        else $error("write response not raised");
endmodule // buzzer_tone_envelope_oneshot

// ==== pkg/buzzer_map.svh ====
`ifndef BUZZER_MAP_SVH
`define BUZZER_MAP_SVH
// ----------------------------------------
// Register indexes, byte address = 4 x index
// ----------------------------------------
`define IDX_PORT 12'hf54
`define IDX_FREQ 12'hf74
`define IDX_ENV 12'hf75
`define RST_PORT 4'hf
`define RST_FREQ 4'h0
`define RST_ENV 4'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_TONE_OUT 3
`define F_TONE_INV 2
`define F_BURST_LEN 3
`define F_BURST_TRIG 3
`define F_ENV_RST 2
`define F_ENV_RATE 1
`define F_ENV_EN 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define SUB_HZ 65536
`define SYNC_HZ 256
`define US_PER_S 1000000
`define STEP_FAST_US 62500
`define STEP_SLOW_US 125000
`define BURST_SHORT_US 31250
`define BURST_LONG_US 62500
`define LEVEL_MIN 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== pkg/buzzer_pkg.sv ====
package buzzer_pkg;
`include "buzzer_map.svh"

typedef enum logic [1:0] {SEL_NONE, SEL_PORT, SEL_FREQ, SEL_ENV} reg_sel_type;

typedef struct packed {
    logic tone_out_ctrl;
    logic tone_inv_out_ctrl;
    logic [1:0] port_spare;
    logic burst_length_sel;
    logic [2:0] tone_freq_sel;
    logic envelope_rate_sel;
    logic envelope_enable;
} ctrl_type;

typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
} wr_type;

function automatic reg_sel_type reg_decode(input logic [15:0] a);
    if (a[15:14] != 2'h0) return SEL_NONE;
    case (a[13:2])
        `IDX_PORT: return SEL_PORT;
        `IDX_FREQ: return SEL_FREQ;
        `IDX_ENV: return SEL_ENV;
        default: return SEL_NONE;
    endcase
endfunction

// Period in sub-units per frequency group
function automatic logic [4:0] tone_period(input logic [1:0] g);
    return 5'h10 + {1'b0, g, 2'h0};
endfunction

// High time: max 8,8,12,12 minus the envelope level
function automatic logic [4:0] tone_high(input logic [1:0] g, input logic [2:0] lvl);
    return (g[1] ? 5'hc : 5'h8) - {2'h0, lvl};
endfunction
endpackage

// ==== hw/tone_wave.sv ====
`timescale 1ns/1ns
module tone_wave (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic sub_tick,
    input wire logic run,
    input wire logic [2:0] freq_sel,
    input wire logic [2:0] level,
    // Waveform
    output logic wave_r
);
    import buzzer_pkg::*;

    logic half_r, half_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic wave_nxt;
    logic step;

    // ----------------------------------------
    // Sub-unit counter
    // ----------------------------------------
    always_comb begin
        half_nxt = half_r ^ sub_tick;
        // Codes with bit 2 set run the sub-unit at half rate
        step = sub_tick && (!freq_sel[2] || half_r);
        cnt_nxt = cnt_r;
        if (!run)
            cnt_nxt = 5'h0;
        else if (step)
            // Period shrink after a code change wraps at once; a glitch is accepted
            cnt_nxt = (cnt_r >= tone_period(freq_sel[1:0]) - 5'h1) ? 5'h0 : cnt_r + 5'h1;
        wave_nxt = run && (cnt_r < tone_high(freq_sel[1:0], level));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_r <= 1'b0;
            cnt_r <= 5'h0;
            wave_r <= 1'b0;
        end else if (ce) begin
            half_r <= half_nxt;
            cnt_r <= cnt_nxt;
            wave_r <= wave_nxt;
        end
    end
endmodule // tone_wave

// ==== dv/piezo_model.sv ====
`timescale 1ns/1ns
// Passive buzzer load: measures period, high time and rising edges of the tone terminal
module piezo_model (
    // Clock
    input wire logic aclk,
    // Terminals
    input wire logic tone_out,
    input wire logic tone_inv_out,
    // Measurements
    output logic [15:0] period,
    output logic [15:0] high_time,
    output logic [31:0] rises,
    output logic inv_bad
);
    logic prev_r = 1'b0;
    logic [15:0] cnt_r = 16'h0;
    initial begin
        period = 16'h0;
        high_time = 16'h0;
        rises = 32'h0;
        inv_bad = 1'b0;
    end
    // A piezo cannot be driven high from both sides at once
    always @(posedge aclk) begin
        prev_r <= tone_out;
        cnt_r <= cnt_r + 16'h1;
        if (tone_out === 1'b1 && tone_inv_out === 1'b1) begin
            inv_bad <= 1'b1;
        end
        if (tone_out && !prev_r) begin
            period <= cnt_r;
            cnt_r <= 16'h1;
            rises <= rises + 32'h1;
        end
        if (!tone_out && prev_r) begin
            high_time <= cnt_r;
        end
    end
endmodule // piezo_model

// ==== dv/buzzer_tone_envelope_oneshot_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module buzzer_tone_envelope_oneshot_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ce = 1'b1;
    logic [3:0] wstrb = 4'h1;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, tone_out, tone_inv_out, inv_bad;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rd, rises, r0;
    logic [15:0] period, high_time;
    int n_mismatch = 0, tests_run = 0, cyc = 0, t0, d, n;
    localparam logic [15:0] A_PORT = 16'h3d50, A_FREQ = 16'h3dd0, A_ENV = 16'h3dd4, A_BAD = 16'h3d54;
    always #50 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    buzzer_tone_envelope_oneshot #(.CLK_HZ(65536), .INV_OPTION(1'b1)) dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .tone_out(tone_out), .tone_inv_out(tone_inv_out));
    piezo_model buzzer (.aclk(aclk), .tone_out(tone_out), .tone_inv_out(tone_inv_out),
        .period(period), .high_time(high_time), .rises(rises), .inv_bad(inv_bad));
    task report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task hang;
        n_mismatch++;
        $display("MISMATCH t=%0t wait limit reached", $time);
        report_and_stop;
    endtask
    task wr(input logic [15:0] a, input logic [3:0] v, output logic [1:0] r);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= {28'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
            if (++k > 50) hang;
        end
        // Response ready stays up, so back-to-back calls never drive it twice in one step
        r = bresp;
    endtask
    task rdr(input logic [15:0] a, output logic [31:0] v, output logic [1:0] r);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
            if (++k > 50) hang;
        end
        v = rdata;
        r = rresp;
    endtask
    // Write and read back in one call keeps each scenario short
    task wchk(input logic [15:0] a, input logic [3:0] v, input logic [31:0] e);
        wr(a, v, rs);
        rdr(a, rd, rs);
        `CHK(rd, e)
    endtask
    task wait_rises(input int m);
        int k;
        k = 0;
        r0 = rises;
        while (rises < r0 + m) begin
            @(posedge aclk);
            if (++k > 2000) hang;
        end
    endtask
    task tick_to(input int t);
        while (cyc < t) @(posedge aclk);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK({tone_out, tone_inv_out}, 2'b00)
        rdr(A_PORT, rd, rs); `CHK(rd, 32'hf)
        rdr(A_FREQ, rd, rs); `CHK(rd, 32'h0)
        rdr(A_ENV, rd, rs); `CHK(rd, 32'h0)
        rdr(A_BAD, rd, rs); `CHK({rs, rd}, {2'h2, 32'h0})
        wr(A_BAD, 4'h3, rs); `CHK(rs, 2'h2)
        wchk(A_FREQ, 4'hf, 32'hf);
        // Byte lane 0 off: the write is answered but leaves the register alone
        wstrb <= 4'h0;
        wr(A_FREQ, 4'h0, rs);
        wstrb <= 4'h1;
        `CHK(rs, 2'h0)
        rdr(A_FREQ, rd, rs);
        `CHK(rd, 32'hf)
        wchk(A_ENV, 4'h7, 32'h3);
        wchk(A_ENV, 4'h0, 32'h0);
        // Inverted terminal keeps toggling although its control bit is one
        wchk(A_PORT, 4'h7, 32'h7);
        for (int c = 0; c < 8; c++) begin
            wr(A_FREQ, c[3:0], rs);
            wait_rises(3);
            `CHK(period, 16'(16 + 4 * c[1:0]) << c[2])
            `CHK(high_time, 16'(c[1] ? 12 : 8) << c[2])
            `CHK(tone_inv_out, ~tone_out)
        end
        // Clock enable low must freeze the running tone
        ce <= 1'b0;
        repeat (2) @(posedge aclk);
        r0 = rises;
        d = tone_out;
        repeat (100) @(posedge aclk);
        `CHK({rises, tone_out}, {r0, d[0]})
        ce <= 1'b1;
        wr(A_FREQ, 4'h0, rs);
        wr(A_PORT, 4'hc, rs);
        repeat (40) @(posedge aclk);
        `CHK({tone_out, tone_inv_out, inv_bad}, 3'b000)
        wr(A_PORT, 4'h4, rs);
        // Fast envelope: one level every 4096 sub-ticks, holds the minimum
        wr(A_ENV, 4'h1, rs);
        t0 = cyc;
        for (int k = 0; k < 9; k++) begin
            tick_to(t0 + k * 4096 + 2048);
            `CHK(high_time, 16'(k > 7 ? 1 : 8 - k))
        end
        wr(A_PORT, 4'hc, rs);
        wr(A_ENV, 4'h5, rs);
        wr(A_PORT, 4'h4, rs);
        wait_rises(3);
        `CHK(high_time, 16'h1)
        wr(A_ENV, 4'h5, rs);
        wait_rises(3);
        `CHK(high_time, 16'h8)
        wr(A_ENV, 4'h0, rs);
        wait_rises(3);
        `CHK(high_time, 16'h8)
        wr(A_ENV, 4'h3, rs);
        t0 = cyc;
        // Past the point where the fast rate would already have stepped
        tick_to(t0 + 6144);
        `CHK(high_time, 16'h8)
        tick_to(t0 + 12288);
        `CHK(high_time, 16'h7)
        wr(A_ENV, 4'h0, rs);
        // Trigger with continuous tone on must be ignored
        wr(A_ENV, 4'h8, rs);
        rdr(A_ENV, rd, rs); `CHK(rd, 32'h0)
        wr(A_PORT, 4'hc, rs);
        for (int len = 0; len < 2; len++) begin
            wr(A_FREQ, {len[0], 3'h0}, rs);
            r0 = rises;
            wr(A_ENV, 4'h8, rs);
            t0 = cyc;
            n = 0;
            do begin
                rdr(A_ENV, rd, rs);
                if (++n > 3000) hang;
            end while (rd[3] === 1'b1);
            d = cyc - t0;
            `CHK(n > 1, 1'b1)
            `CHK(d >= (2048 << len) && d <= (2048 << len) + 300, 1'b1)
            `CHK(rises - r0 + 1 >= (128 << len) && rises - r0 <= (128 << len) + 1, 1'b1)
            `CHK({tone_out, tone_inv_out, inv_bad}, 3'b000)
        end
        report_and_stop;
    end
endmodule // buzzer_tone_envelope_oneshot_tb_top
